//--- run_logic_pkg.sv
// constants, register map and mode codes for the place-b start/stop command logic
package run_logic_pkg;

	// register byte offsets on the ahb-lite window
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
	localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h04;
	localparam logic [ADDR_W-1:0] POT_REF_OFS = 8'h08;

	// control register fields
	localparam int CTRL_CODE_LSB = 0;
	localparam int CTRL_CODE_W = 3;
	localparam int CTRL_IN1_REV_BIT = 3;
	localparam int CTRL_POLICY_LSB = 4;
	localparam int CTRL_POLICY_W = 2;

	// status register fields
	localparam int STAT_RUN_BIT = 0;
	localparam int STAT_REV_BIT = 1;
	localparam int STAT_BLOCK_BIT = 2;
	localparam int STAT_IN_LSB = 3;
	localparam int STAT_PERMIT_BIT = 6;

	localparam int POT_W = 16;

	// htrans encodings used by the slave
	localparam logic [1:0] HTRANS_NONSEQ = 2'b10;

	typedef enum logic [2:0] {
		CODE_TWO_WIRE = 3'b000,
		CODE_RUN_DIR = 3'b001,
		CODE_RUN_ENABLE = 3'b010,
		CODE_PULSE = 3'b011,
		CODE_EDGE_FR = 3'b100,
		CODE_EDGE_DIR = 3'b101,
		CODE_EDGE_ENABLE = 3'b110,
		CODE_SPARE = 3'b111
	} run_logic_t;

	typedef enum logic [1:0] {
		POT_NO_RESET = 2'b00,
		POT_RESET_STOP = 2'b01,
		POT_RESET_PDOWN = 2'b10,
		POT_SPARE = 2'b11
	} pot_policy_t;

	// values after reset
	localparam run_logic_t CODE_RST = CODE_TWO_WIRE;
	localparam pot_policy_t POLICY_RST = POT_NO_RESET;
	localparam logic IN1_REV_RST = 1'b0;
	localparam logic BLOCK_RST = 1'b1;
	localparam logic [POT_W-1:0] POT_RST = 16'h0000;

endpackage : run_logic_pkg

//--- contact_sampler.sv
// one contact input: clocked sample, previous sample and rising-edge flag
`timescale 1ns/100ps
module contact_sampler (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic contact,
	output logic level_r,
	output logic rise
);
	logic prev_r;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			level_r <= 1'b0;
			prev_r <= 1'b0;
		end else begin
			level_r <= contact;
			prev_r <= level_r;
		end
	end

	// edge against the previous registered sample only
	assign rise = level_r & ~prev_r;

endmodule : contact_sampler

//--- run_command_logic_place_b.sv
// start/stop/direction command logic for control place b with ahb-lite registers
`timescale 1ns/100ps
module run_command_logic_place_b
	import run_logic_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic contact_in1,
	input wire logic contact_in2,
	input wire logic contact_in3,
	input wire logic run_permit,
	input wire logic fault_reset,
	input wire logic place_change,
	input wire logic power_restore,
	input wire logic power_down,
	output logic run_cmd,
	output logic reverse_cmd,
	output logic start_blocked,
	output logic [POT_W-1:0] pot_ref
);
	logic s1, s2, s3, permit_s;
	logic rise2, rise3;
	run_logic_t run_logic_code;
	pot_policy_t pot_reset_policy;
	logic in1_rev_en_r;
	logic run_r, run_nxt;
	logic rev_r, rev_nxt;
	logic block_r;
	logic [POT_W-1:0] pot_ref_r;
	logic wr_pend_r;
	logic [ADDR_W-1:0] wr_addr_r;
	logic [31:0] hrdata_r;
	logic addr_phase;
	logic pot_we;
	logic edge_code;
	logic start_open;
	logic block_set;
	logic stop_entry;
	logic [31:0] status_word;

	contact_sampler u_in1 (
		.sys_clk(sys_clk),
		.rst(rst),
		.contact(contact_in1),
		.level_r(s1),
		.rise()
	);
	contact_sampler u_in2 (
		.sys_clk(sys_clk),
		.rst(rst),
		.contact(contact_in2),
		.level_r(s2),
		.rise(rise2)
	);
	contact_sampler u_in3 (
		.sys_clk(sys_clk),
		.rst(rst),
		.contact(contact_in3),
		.level_r(s3),
		.rise(rise3)
	);
	contact_sampler u_permit (
		.sys_clk(sys_clk),
		.rst(rst),
		.contact(run_permit),
		.level_r(permit_s),
		.rise()
	);

	// ahb-lite slave: zero wait states, always okay
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_r;
	assign addr_phase = hsel & hready & htrans[1];
	assign pot_we = wr_pend_r & (wr_addr_r == POT_REF_OFS);

	always_comb begin
		status_word = 32'h0000_0000;
		status_word[STAT_RUN_BIT] = run_r;
		status_word[STAT_REV_BIT] = rev_r;
		status_word[STAT_BLOCK_BIT] = block_r;
		status_word[STAT_IN_LSB +: 3] = {s3, s2, s1};
		status_word[STAT_PERMIT_BIT] = permit_s;
	end

	// write lands at the end of the data phase, once hwdata stands
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= '0;
		end else begin
			wr_pend_r <= addr_phase & hwrite;
			wr_addr_r <= haddr[ADDR_W-1:0];
		end
	end

	// read data loaded at the address phase; unmapped offsets read zero
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			hrdata_r <= 32'h0000_0000;
		end else if (addr_phase & ~hwrite) begin
			case (haddr[ADDR_W-1:0])
				CTRL_OFS: begin
					hrdata_r <= {26'h0, pot_reset_policy, in1_rev_en_r, run_logic_code};
				end
				STATUS_OFS: begin
					hrdata_r <= status_word;
				end
				POT_REF_OFS: begin
					hrdata_r <= {16'h0000, pot_ref_r};
				end
				default: begin
					hrdata_r <= 32'h0000_0000;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			run_logic_code <= CODE_RST;
			pot_reset_policy <= POLICY_RST;
			in1_rev_en_r <= IN1_REV_RST;
		end else if (wr_pend_r & (wr_addr_r == CTRL_OFS)) begin
			run_logic_code <= run_logic_t'(hwdata[CTRL_CODE_LSB +: CTRL_CODE_W]);
			pot_reset_policy <= pot_policy_t'(hwdata[CTRL_POLICY_LSB +: CTRL_POLICY_W]);
			in1_rev_en_r <= hwdata[CTRL_IN1_REV_BIT];
		end
	end

	// lockout is tracked in every code but gates only the edge codes
	assign edge_code = (run_logic_code == CODE_EDGE_FR) | (run_logic_code == CODE_EDGE_DIR)
		| (run_logic_code == CODE_EDGE_ENABLE);

	always_comb begin
		run_nxt = 1'b0;
		rev_nxt = rev_r;
		case (run_logic_code)
			CODE_TWO_WIRE: begin
				// both contacts closed is ambiguous, so the drive stops
				run_nxt = s2 ^ s3;
				rev_nxt = s3 & ~s2;
			end
			CODE_RUN_DIR: begin
				run_nxt = s2;
				rev_nxt = s3;
			end
			CODE_RUN_ENABLE: begin
				run_nxt = s2 & s3;
				rev_nxt = 1'b0;
			end
			CODE_PULSE: begin
				if (!s3) begin
					run_nxt = 1'b0;
				end else if (rise2) begin
					run_nxt = 1'b1;
				end else begin
					run_nxt = run_r;
				end
				rev_nxt = in1_rev_en_r & s1;
			end
			CODE_EDGE_FR: begin
				if (run_r) begin
					run_nxt = rev_r ? s3 : s2;
				end else if (!block_r && rise2) begin
					run_nxt = 1'b1;
					rev_nxt = 1'b0;
				end else if (!block_r && rise3) begin
					run_nxt = 1'b1;
					rev_nxt = 1'b1;
				end
			end
			CODE_EDGE_DIR: begin
				run_nxt = run_r ? s2 : (rise2 & ~block_r);
				rev_nxt = s3;
			end
			CODE_EDGE_ENABLE: begin
				run_nxt = s3 & (run_r ? s2 : (rise2 & ~block_r));
				rev_nxt = 1'b0;
			end
			default: begin
				run_nxt = 1'b0;
			end
		endcase
		if (!permit_s) begin
			run_nxt = 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			run_r <= 1'b0;
			rev_r <= 1'b0;
		end else begin
			run_r <= run_nxt;
			rev_r <= rev_nxt;
		end
	end

	// start lockout: set by events, released once the start contact reads open, or in code 4 once both start contacts read open
	assign start_open = (run_logic_code == CODE_EDGE_FR) ? (~s2 & ~s3) : ~s2;
	assign block_set = fault_reset | place_change | power_restore | (run_r & ~permit_s);

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			block_r <= BLOCK_RST;
		end else if (block_set) begin
			block_r <= 1'b1;
		end else if (start_open) begin
			block_r <= 1'b0;
		end
	end

	// potentiometer reference; a hardware clear beats a software write
	assign stop_entry = run_r & ~run_nxt;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pot_ref_r <= POT_RST;
		end else if ((pot_reset_policy == POT_RESET_STOP) && (stop_entry || power_down)) begin
			pot_ref_r <= '0;
		end else if ((pot_reset_policy == POT_RESET_PDOWN) && power_down) begin
			pot_ref_r <= '0;
		end else if (pot_we) begin
			pot_ref_r <= hwdata[POT_W-1:0];
		end
	end

	assign run_cmd = run_r;
	assign reverse_cmd = rev_r;
	assign start_blocked = block_r;
	assign pot_ref = pot_ref_r;

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);

	chk_code0_level: assert property (
		(run_logic_code == CODE_TWO_WIRE) && permit_s |=> run_r == ($past(s2) ^ $past(s3))
			&& rev_r == ($past(s3) & ~$past(s2)))
		else $error("code 0 run or direction wrong");
	chk_code1_level: assert property (
		(run_logic_code == CODE_RUN_DIR) && permit_s |=> run_r == $past(s2) && rev_r == $past(s3))
		else $error("code 1 run or direction wrong");
	chk_code2_enable: assert property (
		(run_logic_code == CODE_RUN_ENABLE) && (!s3 || !s2) |=> !run_r)
		else $error("code 2 ran without start and enable");
	chk_pulse_start: assert property (
		(run_logic_code == CODE_PULSE) && permit_s && s3 && rise2 |=> run_r ##1 (run_r
			|| !$past(s3) || !$past(permit_s) || $past(run_logic_code) != CODE_PULSE))
		else $error("code 3 pulse start failed");
	chk_edge_only: assert property (
		(run_logic_code == CODE_EDGE_FR) && !run_r && !rise2 && !rise3 |=> !run_r)
		else $error("code 4 started without an edge");
	chk_code5_stop: assert property (
		(run_logic_code == CODE_EDGE_DIR) && !s2 |=> !run_r && rev_r == $past(s3))
		else $error("code 5 stop or direction wrong");
	chk_code6_stop: assert property (
		(run_logic_code == CODE_EDGE_ENABLE) && (!s3 || !s2) |=> !run_r)
		else $error("code 6 did not stop");
	chk_block_start: assert property (
		edge_code && block_r && !run_r |=> !run_r)
		else $error("start taken while blocked");
	chk_block_event: assert property (
		fault_reset || place_change |=> block_r)
		else $error("lockout not armed by event");
	chk_pot_stop_clear: assert property (
		($past(pot_reset_policy) == POT_RESET_STOP) && $fell(run_r) |-> pot_ref_r == '0)
		else $error("reference not cleared at stop");
	chk_pot_keep_stop: assert property (
		(pot_reset_policy != POT_RESET_STOP) && stop_entry && !pot_we && !power_down
			|=> $stable(pot_ref_r))
		else $error("reference lost at stop");
	chk_pdown_clear: assert property (
		(pot_reset_policy == POT_RESET_PDOWN) && power_down |=> pot_ref_r == '0)
		else $error("reference not cleared at power-down");
	chk_pdown_stop_clear: assert property (
		(pot_reset_policy == POT_RESET_STOP) && power_down |=> pot_ref_r == '0)
		else $error("policy 1 reference not cleared at power-down");
	chk_pdown_keep: assert property (
		(pot_reset_policy == POT_NO_RESET) && power_down && !pot_we |=> $stable(pot_ref_r))
		else $error("policy 0 reference lost at power-down");
	chk_contact_sample: assert property (
		!$past(rst) |-> s2 == $past(contact_in2) && s3 == $past(contact_in3))
		else $error("contact not taken on the clock");
	chk_rise_prev: assert property (
		rise2 == (s2 && !$past(s2)) && rise3 == (s3 && !$past(s3)))
		else $error("edge not against the previous sample");
	chk_permit_stop: assert property (
		!permit_s |=> !run_r)
		else $error("ran without run permit");
	chk_permit_lock: assert property (
		run_r && !permit_s |=> block_r)
		else $error("lockout not armed by permit loss");
	chk_block_clear: assert property (
		!block_set && start_open |=> !block_r)
		else $error("lockout not released with start open");
	chk_pulse_dir: assert property (
		(run_logic_code == CODE_PULSE) |=> rev_r == ($past(in1_rev_en_r) && $past(s1)))
		else $error("code 3 reverse not from first contact");
	chk_edge_fwd: assert property (
		(run_logic_code == CODE_EDGE_FR) && permit_s && !run_r && !block_r && rise2
			|=> run_r && !rev_r)
		else $error("code 4 forward start missed");
	chk_code5_start: assert property (
		(run_logic_code == CODE_EDGE_DIR) && permit_s && !block_r && rise2
			|=> run_r && rev_r == $past(s3))
		else $error("code 5 start missed");
	chk_code6_start: assert property (
		(run_logic_code == CODE_EDGE_ENABLE) && permit_s && s3 && !block_r && rise2
			|=> run_r)
		else $error("code 6 start missed");

	cov_pulse_run: cover property ((run_logic_code == CODE_PULSE) && rise2 ##1 run_r);
	cov_edge_rev: cover property ((run_logic_code == CODE_EDGE_FR) && rise3 ##1 run_r && rev_r);
	cov_block_release: cover property (block_r ##1 !block_r ##[1:20] run_r);
	cov_pot_cleared: cover property ($fell(run_r) && (pot_reset_policy == POT_RESET_STOP));
	cov_permit_lock: cover property (run_r && !permit_s ##1 block_r);

endmodule : run_command_logic_place_b

//--- switch_contacts.sv
// external switch contacts wired to the three digital inputs
`timescale 1ns/100ps
module switch_contacts (
	input wire logic sys_clk,
	input wire logic [2:0] want,
	output logic contact_in1,
	output logic contact_in2,
	output logic contact_in3
);
	// contacts are registered on the rising edge, so the sampler takes each change one edge later
	// the operator reopens the start contact before any new start
	always @(posedge sys_clk) begin
		{contact_in3, contact_in2, contact_in1} <= want;
	end
endmodule : switch_contacts

//--- test_run_command_logic_place_b.sv
// self-checking bench for the place-b start/stop command logic
`timescale 1ns/100ps
module test_run_command_logic_place_b;
	import run_logic_pkg::*;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic run_permit = 1'b1;
	logic [3:0] evt = 4'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [2:0] want = 3'h0;
	logic [31:0] hrdata, rd;
	logic hreadyout, hresp, in1, in2, in3, run_cmd, reverse_cmd, start_blocked;
	logic [POT_W-1:0] pot_ref;
	logic [15:0] lfsr = 16'hC98F;
	int miscompares = 0;
	int n_tests = 0;
	// code, contacts {in3,in2,in1}, expected run, expected reverse
	int plan[$] = '{0, 2, 1, 0, 0, 4, 1, 1, 0, 0, 0, 0,
		1, 2, 1, 0, 1, 6, 1, 1, 1, 0, 0, 0,
		2, 2, 0, 0, 2, 6, 1, 0, 2, 2, 0, 0, 2, 0, 0, 0,
		3, 4, 0, 0, 3, 6, 1, 0, 3, 4, 1, 0, 3, 5, 1, 1, 3, 0, 0, 0,
		4, 2, 1, 0, 4, 0, 0, 0, 4, 4, 1, 1, 4, 0, 0, 1,
		5, 2, 1, 0, 5, 6, 1, 1, 5, 0, 0, 0,
		6, 2, 0, 0, 6, 6, 0, 0, 6, 4, 0, 0, 6, 6, 1, 0, 6, 2, 0, 0, 6, 0, 0, 0};
	int cur = -1;

	always #2 sys_clk = ~sys_clk;

	run_command_logic_place_b DUT (.sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .contact_in1(in1),
		.contact_in2(in2), .contact_in3(in3), .run_permit(run_permit), .fault_reset(evt[0]),
		.place_change(evt[1]), .power_restore(evt[2]), .power_down(evt[3]),
		.run_cmd(run_cmd), .reverse_cmd(reverse_cmd), .start_blocked(start_blocked),
		.pot_ref(pot_ref));

	switch_contacts u_sw (.sys_clk(sys_clk), .want(want), .contact_in1(in1),
		.contact_in2(in2), .contact_in3(in3));

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	function automatic logic [15:0] lfsr_next(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction : lfsr_next

	task automatic conclude();
		if (miscompares == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : conclude

	// single word transfer; address phase held until hready, data phase likewise
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge sys_clk);
		hsel <= 1'b1;
		htrans <= HTRANS_NONSEQ;
		hwrite <= wr;
		haddr <= {24'h0, a};
		@(posedge sys_clk);
		while (hreadyout !== 1'b1) @(posedge sys_clk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge sys_clk);
		while (hreadyout !== 1'b1) @(posedge sys_clk);
		rd = hrdata;
		chk(hresp, 1'b0);
	endtask : bus

	task automatic setc(input int c, input int p);
		bus(1'b1, CTRL_OFS, 32'(c + 8 + p * 16));
	endtask : setc

	// pin to output takes three edges; the fourth leaves margin
	task automatic step(input logic [2:0] w, input logic er, input logic ev);
		@(posedge sys_clk);
		want <= w;
		repeat (4) @(posedge sys_clk);
		chk(run_cmd, er);
		chk(reverse_cmd, ev);
	endtask : step

	task automatic pulse(input int i);
		@(posedge sys_clk);
		evt[i] <= 1'b1;
		@(posedge sys_clk);
		evt[i] <= 1'b0;
		repeat (3) @(posedge sys_clk);
	endtask : pulse

	initial begin
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		chk(start_blocked, 1);
		chk(pot_ref, 0);
		bus(1'b0, 8'h0C, 32'h0);
		chk(rd, 0);
		while (plan.size() > 0) begin
			if (plan[0] != cur) begin
				cur = plan[0];
				setc(cur, 0);
			end
			step(plan[1], plan[2], plan[3]);
			repeat (4) void'(plan.pop_front());
		end
		bus(1'b0, CTRL_OFS, 32'h0);
		chk(rd, 32'h0E);
		// code 3 with the first contact not wired as reverse
		bus(1'b1, CTRL_OFS, 32'h3);
		step(3'h5, 0, 0);
		step(3'h7, 1, 0);
		step(3'h0, 0, 0);
		for (int i = 0; i < 3; i++) begin
			setc(7, 0);
			step(3'h2, 0, 0);
			pulse(i);
			setc(5, 0);
			step(3'h2, 0, 0);
			chk(start_blocked, 1);
			step(3'h0, 0, 0);
			chk(start_blocked, 0);
			step(3'h2, 1, 0);
			bus(1'b0, STATUS_OFS, 32'h0);
			chk(rd, 32'h51);
			@(posedge sys_clk);
			run_permit <= 1'b0;
			repeat (4) @(posedge sys_clk);
			chk(run_cmd, 0);
			chk(start_blocked, 1);
			run_permit <= 1'b1;
			step(3'h2, 0, 0);
			step(3'h0, 0, 0);
		end
		for (int p = 0; p < 4; p++) begin
			lfsr = lfsr_next(lfsr);
			setc(0, p);
			bus(1'b1, POT_REF_OFS, {16'h0, lfsr});
			step(3'h2, 1, 0);
			step(3'h0, 0, 0);
			chk(pot_ref, (p == 1) ? 16'h0 : lfsr);
			// reload so the power-down clear is seen under policies 1 and 2 and the kept value under 0 and 3
			bus(1'b1, POT_REF_OFS, {16'h0, lfsr});
			pulse(3);
			chk(pot_ref, (p == 0 || p == 3) ? lfsr : 16'h0);
			bus(1'b0, POT_REF_OFS, 32'h0);
			chk(rd, (p == 0 || p == 3) ? {16'h0, lfsr} : 32'h0);
		end
		conclude();
	end

	initial begin
		repeat (20000) @(posedge sys_clk);
		miscompares++;
		conclude();
	end
endmodule : test_run_command_logic_place_b
